// ### src/switch_pm_consts.svh
// offsets, field positions, masks and reset values of the csr bank
// assumes 12-bit configuration byte addresses, one 32-bit word each
`ifndef SWITCH_PM_CONSTS_SVH
`define SWITCH_PM_CONSTS_SVH

`define OFF_NO_SNOOP 12'h234
`define OFF_SUB_HDR 12'h240
`define OFF_SUB_CAP 12'h244
`define OFF_SUB_CTL1 12'h248
`define OFF_SUB_CTL2 12'h24c
`define OFF_LINK_TRAIN 12'h33c
`define OFF_HOT_MEDIA 12'h340
`define OFF_SB_CTL 12'h344
`define OFF_CPL_FC_EN 12'h350

`define NS_VALUE_LSB 16
`define NS_VALUE_MSB 25
`define NS_SCALE_LSB 26
`define NS_SCALE_MSB 28
`define NO_SNOOP_MASK 32'h1fff_0000
`define NO_SNOOP_RST 32'h0000_0000

`define SUB_HDR_WORD 32'h0001_001e
`define SUB_CAP_MASK 32'h0000_001a
`define SUB_CAP_RST 32'h0000_0012
`define SUB_CTL1_MASK 32'h0000_000a
`define SUB_CTL2_WORD 32'h0000_0000
`define PCIPM_BIT 1
`define ASPM_BIT 3

`define LINK_TRAIN_MASK 32'h0000_00ff
`define LINK_TRAIN_RST 32'h0000_0000
`define HOT_RST 16'h0000
`define MEDIA_RST 16'h0004

`define SB_CTL_RW_MASK 32'h0000_02ff
`define SB_CTL_RST 32'h0000_02d1
`define SB_SEL_BIT 0
`define SB_ADDR_LSB 1
`define SB_ADDR_MSB 7
`define SB_STRAP_LSB 1
`define SB_STRAP_MSB 3
`define SB_PEC_DIS_BIT 9
`define SB_PEC_FAIL_BIT 29
`define SB_BAD_CMD_BIT 30

`define CPL_FC_MASK 32'h0000_0006
`define CPL_FC_LSB 1

`define THR_X1_RST 16'h0080
`define THR_X2_RST 16'h0200
`define THR_X4_RST 16'h0800

`endif

// ### src/switch_pm_pkg.sv
// types shared by the power-management csr bank and its helpers
// assumes the constants header sits beside it
package switch_pm_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } cfg_req_t;

  typedef struct packed {
    logic valid;
    logic [11:0] addr;
    logic [31:0] data;
  } load_t;

  typedef struct packed {
    logic pec_fail;
    logic pec_pass;
    logic bad_cmd;
  } sb_event_t;

  typedef struct packed {
    logic pcipm_l11_en;
    logic aspm_l11_en;
  } pm_ctl_t;

  typedef enum logic [1:0] {
    WIDTH_X1,
    WIDTH_X2,
    WIDTH_X4,
    WIDTH_NONE
  } link_width_t;

endpackage

// ### src/sticky_flag_bank.sv
// sticky event flags, cleared by software or by a hardware clear
// assumes one-cycle set and clear pulses on the core clock
`timescale 1ns/10ps
module sticky_flag_bank #(
  parameter int N = 2
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [N-1:0] set_in,
  input wire logic [N-1:0] sw_clear_in,
  input wire logic [N-1:0] hw_clear_in,
  output logic [N-1:0] flag_out
);

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_flag
      wire logic clear = sw_clear_in[i] | hw_clear_in[i];
      // set wins over any clear in the same cycle
      always_ff @(posedge clk_sys_in or negedge rstn_in)
      begin
        if (!rstn_in)
          flag_out[i] <= 1'b0;
        else if (set_in[i])
          flag_out[i] <= 1'b1;
        else if (clear)
          flag_out[i] <= 1'b0;
      end
    end
  endgenerate

endmodule

// ### src/cpl_threshold_pick.sv
// picks the completion flow-control threshold for one port's link width
// assumes the width code is steady while the link is up
`timescale 1ns/10ps
module cpl_threshold_pick
  import switch_pm_pkg::*;
#(
  parameter logic [15:0] THR_X1 = 16'h0080,
  parameter logic [15:0] THR_X2 = 16'h0200,
  parameter logic [15:0] THR_X4 = 16'h0800
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic enable_in,
  input wire switch_pm_pkg::link_width_t width_in,
  output logic [15:0] threshold_out
);

  wire logic [15:0] by_width =
    (width_in == WIDTH_X1) ? THR_X1 :
    (width_in == WIDTH_X2) ? THR_X2 :
    (width_in == WIDTH_X4) ? THR_X4 : 16'h0000;

  // zero means no completion limit applied
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      threshold_out <= 16'h0000;
    else
      threshold_out <= enable_in ? by_width : 16'h0000;
  end

endmodule

// ### src/switch_pm_sideband_csr_bank.sv
// power-management and sideband csr bank for a switch with NPORT ports
// assumes requests and loads synchronous to clk_sys_in, strap pins
// steady around reset release
`timescale 1ns/10ps
`include "switch_pm_consts.svh"
module switch_pm_sideband_csr_bank #(
  parameter int NPORT = 2,
  parameter logic [15:0] THR_X1 = `THR_X1_RST,
  parameter logic [15:0] THR_X2 = `THR_X2_RST,
  parameter logic [15:0] THR_X4 = `THR_X4_RST
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire switch_pm_pkg::cfg_req_t cfg_req_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  input wire switch_pm_pkg::load_t load_in,
  input wire logic [2:0] strap_addr_in,
  input wire switch_pm_pkg::sb_event_t sb_event_in,
  input wire logic [2*NPORT-1:0] port_width_in,
  output logic [9:0] no_snoop_value_out,
  output logic [2:0] no_snoop_scale_out,
  output switch_pm_pkg::pm_ctl_t pm_ctl_out,
  output logic smbus_select_out,
  output logic [6:0] slave_addr_out,
  output logic pec_check_en_out,
  output logic [NPORT-1:0] cpl_fc_enable_out,
  output logic [16*NPORT-1:0] cpl_threshold_out
);

  import switch_pm_pkg::*;

  // byte-lane merge limited to the writable bits
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be,
    input logic [31:0] mask
  );
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~(lanes & mask)) | (wdata & lanes & mask);
  endfunction

  // request decode
  wire logic [11:0] word_addr = {cfg_req_in.addr[11:2], 2'b00};
  wire logic cfg_wr = cfg_req_in.valid & cfg_req_in.write;
  wire logic cfg_rd = cfg_req_in.valid & ~cfg_req_in.write;

  wire logic sel_no_snoop = word_addr == `OFF_NO_SNOOP;
  wire logic sel_sub_hdr = word_addr == `OFF_SUB_HDR;
  wire logic sel_sub_cap = word_addr == `OFF_SUB_CAP;
  wire logic sel_sub_ctl1 = word_addr == `OFF_SUB_CTL1;
  wire logic sel_sub_ctl2 = word_addr == `OFF_SUB_CTL2;
  wire logic sel_link_train = word_addr == `OFF_LINK_TRAIN;
  wire logic sel_hot_media = word_addr == `OFF_HOT_MEDIA;
  wire logic sel_sb_ctl = word_addr == `OFF_SB_CTL;
  wire logic sel_cpl_fc = word_addr == `OFF_CPL_FC_EN;

  // sideband default-load decode
  wire logic [11:0] ld_addr = {load_in.addr[11:2], 2'b00};
  wire logic ld_no_snoop = load_in.valid & (ld_addr == `OFF_NO_SNOOP);
  wire logic ld_sub_cap = load_in.valid & (ld_addr == `OFF_SUB_CAP);
  wire logic ld_sub_ctl1 = load_in.valid & (ld_addr == `OFF_SUB_CTL1);
  wire logic ld_link_train =
    load_in.valid & (ld_addr == `OFF_LINK_TRAIN);
  wire logic ld_hot_media = load_in.valid & (ld_addr == `OFF_HOT_MEDIA);
  wire logic ld_sb_ctl = load_in.valid & (ld_addr == `OFF_SB_CTL);
  wire logic ld_cpl_fc = load_in.valid & (ld_addr == `OFF_CPL_FC_EN);

  // configuration write strobes
  wire logic wr_no_snoop = cfg_wr & sel_no_snoop;
  wire logic wr_sub_ctl1 = cfg_wr & sel_sub_ctl1;
  wire logic wr_sb_ctl = cfg_wr & sel_sb_ctl;
  wire logic wr_cpl_fc = cfg_wr & sel_cpl_fc;

  // storage
  logic [31:0] no_snoop_limit;
  logic [31:0] sub_cap;
  logic [31:0] sub_ctl1;
  logic [31:0] link_train_word;
  logic [15:0] hot_insert_status_word;
  logic [15:0] media_access_status_word;
  logic [31:0] sb_ctl;
  logic [31:0] cpl_fc;
  logic strap_taken;
  logic [1:0] sb_flags;

  wire logic [31:0] next_no_snoop =
    ld_no_snoop ? (load_in.data & `NO_SNOOP_MASK) :
    wr_no_snoop ? merge(no_snoop_limit, cfg_req_in.wdata,
                        cfg_req_in.be, `NO_SNOOP_MASK) :
    no_snoop_limit;

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      no_snoop_limit <= `NO_SNOOP_RST;
    else
      no_snoop_limit <= next_no_snoop;
  end

  wire logic [31:0] next_sub_cap =
    ld_sub_cap ? (load_in.data & `SUB_CAP_MASK) : sub_cap;

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      sub_cap <= `SUB_CAP_RST;
    else
      sub_cap <= next_sub_cap;
  end

  wire logic [31:0] next_sub_ctl1 =
    ld_sub_ctl1 ? (load_in.data & `SUB_CTL1_MASK) :
    wr_sub_ctl1 ? merge(sub_ctl1, cfg_req_in.wdata,
                        cfg_req_in.be, `SUB_CTL1_MASK) :
    sub_ctl1;

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      sub_ctl1 <= 32'h0000_0000;
    else
      sub_ctl1 <= next_sub_ctl1;
  end

  // link training status, loaded only by sideband
  wire logic [31:0] next_link_train =
    ld_link_train ? (load_in.data & `LINK_TRAIN_MASK) : link_train_word;

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      link_train_word <= `LINK_TRAIN_RST;
    else
      link_train_word <= next_link_train;
  end

  // hot-insert and media status halves share one word
  wire logic [15:0] next_hot =
    ld_hot_media ? load_in.data[15:0] : hot_insert_status_word;
  wire logic [15:0] next_media =
    ld_hot_media ? load_in.data[31:16] : media_access_status_word;

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      hot_insert_status_word <= `HOT_RST;
      media_access_status_word <= `MEDIA_RST;
    end
    else
    begin
      hot_insert_status_word <= next_hot;
      media_access_status_word <= next_media;
    end
  end

  // strap bits taken on the first edge after release
  wire logic [31:0] strap_word =
    {29'h0000_0000, strap_addr_in} << `SB_STRAP_LSB;
  wire logic [31:0] strap_mask =
    {29'h0000_0000, 3'h7} << `SB_STRAP_LSB;
  wire logic [31:0] sb_after_strap = strap_taken ? sb_ctl :
    ((sb_ctl & ~strap_mask) | strap_word);

  // mode, address and pec control bits
  wire logic [31:0] next_sb_ctl =
    ld_sb_ctl ? (load_in.data & `SB_CTL_RW_MASK) :
    wr_sb_ctl ? merge(sb_after_strap, cfg_req_in.wdata,
                      cfg_req_in.be, `SB_CTL_RW_MASK) :
    sb_after_strap;

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      sb_ctl <= `SB_CTL_RST;
    else
      sb_ctl <= next_sb_ctl;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      strap_taken <= 1'b0;
    else
      strap_taken <= 1'b1;
  end

  // write-one clear, gated by the byte lane
  wire logic [1:0] flag_sw_clear = {2{wr_sb_ctl & cfg_req_in.be[3]}} &
    {cfg_req_in.wdata[`SB_BAD_CMD_BIT],
     cfg_req_in.wdata[`SB_PEC_FAIL_BIT]};

  // pec results only count while checking is enabled
  wire logic pec_enabled = ~sb_ctl[`SB_PEC_DIS_BIT];

  // pec failure sets, a good check clears
  // unsupported command sets the second flag
  sticky_flag_bank #(
    .N(2)
  ) u_flags (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .set_in({sb_event_in.bad_cmd, sb_event_in.pec_fail & pec_enabled}),
    .sw_clear_in(flag_sw_clear),
    .hw_clear_in({1'b0, sb_event_in.pec_pass & pec_enabled}),
    .flag_out(sb_flags)
  );

  wire logic [31:0] next_cpl_fc =
    ld_cpl_fc ? (load_in.data & `CPL_FC_MASK) :
    wr_cpl_fc ? merge(cpl_fc, cfg_req_in.wdata,
                      cfg_req_in.be, `CPL_FC_MASK) :
    cpl_fc;

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      cpl_fc <= 32'h0000_0000;
    else
      cpl_fc <= next_cpl_fc;
  end

  // sticky flags folded into the control view
  wire logic [31:0] sb_ctl_view = sb_ctl |
    ({31'h0000_0000, sb_flags[0]} << `SB_PEC_FAIL_BIT) |
    ({31'h0000_0000, sb_flags[1]} << `SB_BAD_CMD_BIT);

  // unmapped words and reserved bits read zero
  wire logic [31:0] read_word =
    ({32{sel_no_snoop}} & no_snoop_limit) |
    ({32{sel_sub_hdr}} & `SUB_HDR_WORD) |
    ({32{sel_sub_cap}} & sub_cap) |
    ({32{sel_sub_ctl1}} & sub_ctl1) |
    ({32{sel_sub_ctl2}} & `SUB_CTL2_WORD) |
    ({32{sel_link_train}} & link_train_word) |
    ({32{sel_hot_media}} &
      {media_access_status_word, hot_insert_status_word}) |
    ({32{sel_sb_ctl}} & sb_ctl_view) |
    ({32{sel_cpl_fc}} & cpl_fc);

  // answer one cycle after the request, writes included
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cfg_rdata_out <= 32'h0000_0000;
      cfg_rvalid_out <= 1'b0;
    end
    else
    begin
      cfg_rdata_out <= cfg_rd ? read_word : 32'h0000_0000;
      cfg_rvalid_out <= cfg_req_in.valid;
    end
  end

  // registered copies of the control fields
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      no_snoop_value_out <= 10'h000;
      no_snoop_scale_out <= 3'h0;
      pm_ctl_out <= '0;
    end
    else
    begin
      no_snoop_value_out <=
        next_no_snoop[`NS_VALUE_MSB:`NS_VALUE_LSB];
      no_snoop_scale_out <=
        next_no_snoop[`NS_SCALE_MSB:`NS_SCALE_LSB];
      pm_ctl_out.pcipm_l11_en <= next_sub_ctl1[`PCIPM_BIT];
      pm_ctl_out.aspm_l11_en <= next_sub_ctl1[`ASPM_BIT];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      smbus_select_out <= 1'b1;
      slave_addr_out <= 7'h68;
      pec_check_en_out <= 1'b0;
    end
    else
    begin
      smbus_select_out <= next_sb_ctl[`SB_SEL_BIT];
      slave_addr_out <= next_sb_ctl[`SB_ADDR_MSB:`SB_ADDR_LSB];
      pec_check_en_out <= ~next_sb_ctl[`SB_PEC_DIS_BIT];
    end
  end

  // threshold per port from its link width
  genvar p;
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_port
      wire logic fc_en = cpl_fc[`CPL_FC_LSB + p];
      wire link_width_t width = link_width_t'(port_width_in[2*p +: 2]);

      always_ff @(posedge clk_sys_in or negedge rstn_in)
      begin
        if (!rstn_in)
          cpl_fc_enable_out[p] <= 1'b0;
        else
          cpl_fc_enable_out[p] <= fc_en;
      end

      cpl_threshold_pick #(
        .THR_X1(THR_X1),
        .THR_X2(THR_X2),
        .THR_X4(THR_X4)
      ) u_pick (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .enable_in(fc_en),
        .width_in(width),
        .threshold_out(cpl_threshold_out[16*p +: 16])
      );
    end
  endgenerate

endmodule

// ### test/switch_pm_csr_asserts.sv
// port assertions for the power-management csr bank
// assumes binding onto the bank and the constants header on the path
`timescale 1ns/10ps
`include "switch_pm_consts.svh"
module switch_pm_csr_asserts #(
  parameter int NPORT = 2
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire switch_pm_pkg::cfg_req_t cfg_req_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire switch_pm_pkg::load_t load_in,
  input wire logic [2:0] strap_addr_in,
  input wire switch_pm_pkg::sb_event_t sb_event_in,
  input wire logic [9:0] no_snoop_value_out,
  input wire switch_pm_pkg::pm_ctl_t pm_ctl_out,
  input wire logic [6:0] slave_addr_out,
  input wire logic pec_check_en_out,
  input wire logic [NPORT-1:0] cpl_fc_enable_out
);
  import switch_pm_pkg::*;
  logic [11:0] word;
  logic rd;
  logic wr;
  assign word = {cfg_req_in.addr[11:2], 2'b00};
  assign rd = cfg_req_in.valid && !cfg_req_in.write;
  // a load in the same cycle would win, so writes count only without one
  assign wr = cfg_req_in.valid && cfg_req_in.write && !load_in.valid;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  sequence s_idle;
    !cfg_req_in.valid && !load_in.valid;
  endsequence
  sequence s_rd_sb;
    rd && word == `OFF_SB_CTL;
  endsequence
  hdr_read_a: assert property (rd && word == `OFF_SUB_HDR
    |=> cfg_rdata_out == 32'h0001_001e) else $error("header word wrong");
  cap_rsvd_a: assert property (rd && word == `OFF_SUB_CAP
    |=> (cfg_rdata_out & 32'hffff_ffe5) == 0) else $error("cap reserved set");
  unmapped_zero_a: assert property (rd && word == 12'h100
    |=> cfg_rdata_out == 0) else $error("unmapped read not zero");
  ns_write_a: assert property (wr && word == `OFF_NO_SNOOP
    && cfg_req_in.be[3:2] == 2'b11 |=> no_snoop_value_out ==
    $past(cfg_req_in.wdata[25:16])) else $error("no-snoop value lost");
  pm_write_a: assert property (wr && word == `OFF_SUB_CTL1
    && cfg_req_in.be[0] |=> pm_ctl_out == {$past(cfg_req_in.wdata[1]),
    $past(cfg_req_in.wdata[3])}) else $error("pm enables wrong");
  pec_dis_a: assert property (wr && word == `OFF_SB_CTL
    && cfg_req_in.be[1] |=> pec_check_en_out == !$past(cfg_req_in.wdata[9]))
    else $error("pec enable not inverse of bit 9");
  strap_addr_a: assert property ($rose(rstn_in) ##0 s_idle ##1 s_idle
    |=> slave_addr_out == {4'hd, strap_addr_in}) else $error("strap addr");
  fc_write_a: assert property (wr && word == `OFF_CPL_FC_EN
    && cfg_req_in.be[0] |=> ##1 cpl_fc_enable_out ==
    $past(cfg_req_in.wdata[NPORT:1], 2)) else $error("flow enables wrong");
  bad_cmd_a: assert property (sb_event_in.bad_cmd
    ##1 !cfg_req_in.valid ##1 s_rd_sb |=> cfg_rdata_out[30])
    else $error("bad command flag missing");
  pec_fail_a: assert property (sb_event_in.pec_fail && pec_check_en_out
    ##1 !cfg_req_in.valid && !sb_event_in.pec_pass ##1 s_rd_sb
    |=> cfg_rdata_out[29])
    else $error("pec fail flag missing");
endmodule

bind switch_pm_sideband_csr_bank switch_pm_csr_asserts #(.NPORT(NPORT))
  u_switch_pm_csr_asserts (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .cfg_req_in(cfg_req_in), .cfg_rdata_out(cfg_rdata_out),
  .load_in(load_in), .strap_addr_in(strap_addr_in),
  .sb_event_in(sb_event_in), .no_snoop_value_out(no_snoop_value_out),
  .pm_ctl_out(pm_ctl_out), .slave_addr_out(slave_addr_out),
  .pec_check_en_out(pec_check_en_out),
  .cpl_fc_enable_out(cpl_fc_enable_out));

// ### test/sideband_master_model.sv
// sideband engine stand-in: default word loads and outcome pulses
// assumes tasks are called from the bench on the core clock
`timescale 1ns/10ps
module sideband_master_model (
  input wire logic clk_sys_in,
  output switch_pm_pkg::load_t load_out,
  output switch_pm_pkg::sb_event_t event_out
);
  import switch_pm_pkg::*;
  initial
  begin
    load_out = '0;
    event_out = '0;
  end
  task automatic load_word(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    load_out <= '{1'b1, a, d};
    @(posedge clk_sys_in);
    // released word shows garbage, not the last value
    load_out <= '{1'b0, ~a, ~d};
  endtask
  task automatic pulse(input sb_event_t e);
    @(posedge clk_sys_in);
    event_out <= e;
    @(posedge clk_sys_in);
    event_out <= '0;
  endtask
endmodule

// ### test/test_switch_pm_sideband_csr_bank.sv
// self-checking bench for the power-management csr bank
// assumes the package, header and sideband model are compiled first
`timescale 1ns/10ps
`include "switch_pm_consts.svh"
module test_switch_pm_sideband_csr_bank;
  import switch_pm_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  cfg_req_t cfg_req = '0;
  logic [31:0] rdata;
  logic rvalid;
  load_t load;
  sb_event_t sb_event;
  logic [2:0] strap = 3'b101;
  logic [3:0] port_width = 4'hf;
  logic [9:0] ns_value;
  logic [2:0] ns_scale;
  pm_ctl_t pm_ctl;
  logic smbus_sel;
  logic [6:0] slave_addr;
  logic pec_en;
  logic [1:0] fc_en;
  logic [31:0] thr;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;

  always #2.5 clk_sys_in = ~clk_sys_in;

  switch_pm_sideband_csr_bank u_switch_pm_sideband_csr_bank (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .cfg_req_in(cfg_req),
    .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid), .load_in(load),
    .strap_addr_in(strap), .sb_event_in(sb_event),
    .port_width_in(port_width), .no_snoop_value_out(ns_value),
    .no_snoop_scale_out(ns_scale), .pm_ctl_out(pm_ctl),
    .smbus_select_out(smbus_sel), .slave_addr_out(slave_addr),
    .pec_check_en_out(pec_en), .cpl_fc_enable_out(fc_en),
    .cpl_threshold_out(thr));

  sideband_master_model u_sideband_master_model (.clk_sys_in(clk_sys_in),
    .load_out(load), .event_out(sb_event));

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic access(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
    @(posedge clk_sys_in);
    cfg_req <= '{1'b1, w, a, d, b};
    @(posedge clk_sys_in);
    cfg_req <= '{1'b0, ~w, ~a, ~d, ~b};
    #1;
    check("answer strobe", {31'h0, rvalid}, 32'h1);
    q = rdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] b);
    logic [31:0] q;
    access(1'b1, a, d, b, q);
  endtask

  task automatic rd(input string what, input logic [11:0] a,
    input logic [31:0] exp);
    logic [31:0] q;
    access(1'b0, a, 32'h0, 4'hf, q);
    check(what, q, exp);
  endtask

  task automatic test_reset;
    rd("no snoop", `OFF_NO_SNOOP, 32'h0);
    rd("header", `OFF_SUB_HDR, 32'h0001_001e);
    rd("caps", `OFF_SUB_CAP, 32'h12);
    rd("ctl one", `OFF_SUB_CTL1, 32'h0);
    rd("ctl two", `OFF_SUB_CTL2, 32'h0);
    rd("link", `OFF_LINK_TRAIN, 32'h0);
    rd("hot media", `OFF_HOT_MEDIA, 32'h0004_0000);
    rd("sb ctl", `OFF_SB_CTL, 32'h2db);
    rd("flow en", `OFF_CPL_FC_EN, 32'h0);
    rd("unmapped", 12'h100, 32'h0);
    check("slave addr", {25'h0, slave_addr}, 32'h6d);
    check("pec en", {31'h0, pec_en}, 32'h0);
    $display("test_reset done");
  endtask

  task automatic test_rw;
    wr(`OFF_NO_SNOOP, 32'hffff_ffff, 4'hf);
    rd("no snoop all", `OFF_NO_SNOOP, 32'h1fff_0000);
    check("ns value", {22'h0, ns_value}, 32'h3ff);
    check("ns scale", {29'h0, ns_scale}, 32'h7);
    wr(`OFF_NO_SNOOP, 32'h0, 4'b0100);
    rd("no snoop lane", `OFF_NO_SNOOP, 32'h1f00_0000);
    wr(`OFF_SUB_CTL1, 32'hffff_ffff, 4'hf);
    rd("ctl one", `OFF_SUB_CTL1, 32'ha);
    check("pm ctl", {30'h0, pm_ctl}, 32'h3);
    wr(`OFF_SUB_HDR, 32'hffff_ffff, 4'hf);
    rd("header ro", `OFF_SUB_HDR, 32'h0001_001e);
    wr(`OFF_SUB_CAP, 32'h0, 4'hf);
    rd("caps ro", `OFF_SUB_CAP, 32'h12);
    wr(`OFF_CPL_FC_EN, 32'hffff_ffff, 4'hf);
    rd("flow en", `OFF_CPL_FC_EN, 32'h6);
    check("fc en", {30'h0, fc_en}, 32'h3);
    $display("test_rw done");
  endtask

  task automatic test_load;
    u_sideband_master_model.load_word(`OFF_SUB_CAP, 32'hffff_ffff);
    rd("caps load", `OFF_SUB_CAP, 32'h1a);
    u_sideband_master_model.load_word(`OFF_SUB_CAP, 32'h0);
    rd("caps clear", `OFF_SUB_CAP, 32'h0);
    u_sideband_master_model.load_word(`OFF_LINK_TRAIN, 32'hffff_ffff);
    rd("link load", `OFF_LINK_TRAIN, 32'hff);
    u_sideband_master_model.load_word(`OFF_HOT_MEDIA, 32'h1234_5678);
    rd("hot media load", `OFF_HOT_MEDIA, 32'h1234_5678);
    u_sideband_master_model.load_word(`OFF_NO_SNOOP, 32'hffff_ffff);
    rd("no snoop load", `OFF_NO_SNOOP, 32'h1fff_0000);
    check("ns value load", {22'h0, ns_value}, 32'h3ff);
    u_sideband_master_model.load_word(`OFF_SB_CTL, 32'hffff_ffff);
    rd("sb ctl load", `OFF_SB_CTL, 32'h2ff);
    check("addr load", {25'h0, slave_addr}, 32'h7f);
    $display("test_load done");
  endtask

  task automatic test_sideband;
    wr(`OFF_SB_CTL, 32'h0, 4'hf);
    rd("sb zero", `OFF_SB_CTL, 32'h0);
    check("smbus sel", {31'h0, smbus_sel}, 32'h0);
    check("pec en", {31'h0, pec_en}, 32'h1);
    u_sideband_master_model.pulse(3'b100);
    rd("pec fail", `OFF_SB_CTL, 32'h2000_0000);
    wr(`OFF_SB_CTL, 32'h0, 4'hf);
    rd("w0 keeps", `OFF_SB_CTL, 32'h2000_0000);
    wr(`OFF_SB_CTL, 32'h2000_0000, 4'hf);
    rd("w1 clears", `OFF_SB_CTL, 32'h0);
    u_sideband_master_model.pulse(3'b100);
    u_sideband_master_model.pulse(3'b010);
    rd("pass clears", `OFF_SB_CTL, 32'h0);
    u_sideband_master_model.pulse(3'b001);
    rd("bad cmd", `OFF_SB_CTL, 32'h4000_0000);
    wr(`OFF_SB_CTL, 32'h4000_02ff, 4'hf);
    rd("sb rw", `OFF_SB_CTL, 32'h2ff);
    check("slave addr", {25'h0, slave_addr}, 32'h7f);
    u_sideband_master_model.pulse(3'b100);
    rd("pec gated", `OFF_SB_CTL, 32'h2ff);
    $display("test_sideband done");
  endtask

  task automatic test_thresh;
    logic [15:0] exp [4] = '{16'h0080, 16'h0200, 16'h0800, 16'h0};
    for (int w = 0; w < 4; w++)
    begin
      @(posedge clk_sys_in);
      port_width <= {2'd2, w[1:0]};
      repeat (3) @(posedge clk_sys_in);
      check("threshold", thr, {16'h0800, exp[w]});
    end
    port_width <= 4'b1000;
    wr(`OFF_CPL_FC_EN, 32'h4, 4'h1);
    repeat (3) @(posedge clk_sys_in);
    check("thr gated", thr, 32'h0800_0000);
    check("fc en", {30'h0, fc_en}, 32'h2);
    $display("test_thresh done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk_sys_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      n_mismatch++;
      test_done;
    end
  end

  initial
  begin
    repeat (6) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    test_reset;
    test_rw;
    test_load;
    test_sideband;
    test_thresh;
    test_done;
  end
endmodule
